/* design/pll_lock_pkg.sv */
package pll_lock_pkg;
    // Field widths of the settings
    localparam int unsigned DIV_CODE_W = 3;
    localparam int unsigned SPEED_W = 2;
    localparam int unsigned COUNT_W = 3;
    localparam int unsigned GAIN_W = 7;
    localparam int unsigned SLIP_W = 2;
    localparam int unsigned ODIV_W = 6;
    // Window timer width, counted in lock-detect clock cycles
    localparam int unsigned WIN_W = 12;
    // Lock-detect clock prescale per speed code: speed 00 fastest
    localparam logic [3:0] SPEED_PRESCALE_0 = 4'h1;
    // Offset magnitude step and limits, microamps
    localparam int unsigned OFFSET_STEP_UA = 5;
    localparam int unsigned OFFSET_MAX_UA = 635;
    // Pump current per code step, in microamps: 50 codes give 1000 uA
    localparam int unsigned PUMP_UA_PER_CODE = 20;
    localparam int unsigned CURRENT_W = 12;
    // Consecutive in-window arrivals needed: 2^(code+LOCK_EXP_BASE)
    localparam int unsigned LOCK_CNT_W = 12;
    localparam logic [3:0] LOCK_EXP_BASE = 4'h2;
    // Oscillator band limits in MHz; output divider limits as divide ratios
    localparam int unsigned VCO_MIN_MHZ = 1500;
    localparam int unsigned VCO_MAX_MHZ = 3000;
    localparam logic [ODIV_W-1:0] ODIV_MIN = 6'h02;
    localparam logic [ODIV_W-1:0] ODIV_MAX = 6'h3E;
    // Window state machine
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT_VCO = 3'b010,
        ST_WAIT_REF = 3'b100
    } win_state_t;
endpackage : pll_lock_pkg

/* design/pll_lock_window_pump_control.sv */
`timescale 1ns/1ps
module pll_lock_window_pump_control #(
    parameter int unsigned LOCK_CNT_W = pll_lock_pkg::LOCK_CNT_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Divided edges at the phase comparator, one-cycle pulses
    input wire logic ref_edge_i,
    input wire logic vco_edge_i,
    // Lock-detect settings
    input wire logic lock_detect_en_i,
    input wire logic timer_window_sel_i,
    input wire logic [pll_lock_pkg::DIV_CODE_W-1:0] timer_divide_i,
    input wire logic [pll_lock_pkg::SPEED_W-1:0] timer_speed_i,
    input wire logic [pll_lock_pkg::COUNT_W-1:0] lock_count_code_i,
    // Pump settings
    input wire logic [pll_lock_pkg::GAIN_W-1:0] pump_down_current_code_i,
    input wire logic [pll_lock_pkg::GAIN_W-1:0] pump_up_current_code_i,
    input wire logic [pll_lock_pkg::GAIN_W-1:0] offset_code_i,
    input wire logic offset_up_en_i,
    input wire logic offset_down_en_i,
    input wire logic [pll_lock_pkg::SLIP_W-1:0] slip_guard_i,
    // Mode and output path
    input wire logic frac_mod_en_i,
    input wire logic mod_bypass_i,
    input wire logic [pll_lock_pkg::ODIV_W-1:0] out_divide_i,
    input wire logic doubler_en_i,
    // Status and decoded controls
    output logic lock_indicator_o,
    output logic gain_boost_o,
    output logic [pll_lock_pkg::CURRENT_W-1:0] pump_up_ua_o,
    output logic [pll_lock_pkg::CURRENT_W-1:0] pump_down_ua_o,
    output logic [pll_lock_pkg::CURRENT_W-1:0] offset_up_ua_o,
    output logic [pll_lock_pkg::CURRENT_W-1:0] offset_down_ua_o,
    output logic integer_mode_o,
    output logic [pll_lock_pkg::ODIV_W-1:0] out_divide_o,
    output logic doubler_o
);

    localparam int unsigned WW = pll_lock_pkg::WIN_W;
    localparam int unsigned CW = pll_lock_pkg::CURRENT_W;
    pll_lock_pkg::win_state_t state_q, state_d;
    logic [WW-1:0] win_cnt_q, win_cnt_d, win_len;
    logic [LOCK_CNT_W-1:0] hit_cnt_q, hit_cnt_d, hit_target;
    logic lock_q, lock_d, boost_q, boost_d;
    logic in_window, out_window;
    logic [CW-1:0] up_ua_d, dn_ua_d, off_ua, offu_d, offd_d;
    logic [CW-1:0] up_ua_q, dn_ua_q, offu_q, offd_q;
    logic int_mode_q, int_mode_d, dbl_q, dbl_d;
    logic [pll_lock_pkg::ODIV_W-1:0] odiv_q, odiv_d;

    // Window length in lock-detect ticks: code n gives 2^n, so the nominal
    // half tick of code 0 rounds up to one; times speed+1, slower = longer
    always_comb
    begin
        win_len = WW'(({{(WW-1){1'b0}}, 1'b1} << timer_divide_i)
            * (WW'(timer_speed_i) + WW'(pll_lock_pkg::SPEED_PRESCALE_0)));
    end

    // Hit target; four-bit exponent so codes 6 and 7 cannot wrap
    always_comb
    begin
        hit_target = LOCK_CNT_W'(({{(LOCK_CNT_W-1){1'b0}}, 1'b1}
            << ({1'b0, lock_count_code_i} + pll_lock_pkg::LOCK_EXP_BASE)));
    end

    // Window timer: opens on whichever edge comes first
    always_comb
    begin
        state_d = state_q;
        win_cnt_d = win_cnt_q;
        in_window = 1'b0;
        out_window = 1'b0;
        case (state_q)
            pll_lock_pkg::ST_IDLE:
            begin
                if (ref_edge_i && vco_edge_i)
                begin
                    in_window = 1'b1; // Coincident edges: zero offset
                end
                else if (ref_edge_i || vco_edge_i)
                begin
                    state_d = ref_edge_i ? pll_lock_pkg::ST_WAIT_VCO
                                         : pll_lock_pkg::ST_WAIT_REF;
                    win_cnt_d = win_len;
                end
            end
            pll_lock_pkg::ST_WAIT_VCO, pll_lock_pkg::ST_WAIT_REF:
            begin
                if ((state_q == pll_lock_pkg::ST_WAIT_VCO && vco_edge_i)
                    || (state_q == pll_lock_pkg::ST_WAIT_REF && ref_edge_i))
                begin
                    in_window = (win_cnt_q != '0);
                    out_window = (win_cnt_q == '0);
                    state_d = pll_lock_pkg::ST_IDLE;
                end
                else if (win_cnt_q != '0)
                begin
                    win_cnt_d = win_cnt_q - WW'(1);
                end
            end
            default:
            begin
                state_d = pll_lock_pkg::ST_IDLE;
            end
        endcase
        if (!lock_detect_en_i)
        begin
            state_d = pll_lock_pkg::ST_IDLE;
            in_window = 1'b0;
            out_window = 1'b0;
        end
    end

    // Lock declaration and slip guard; a miss always clears lock
    always_comb
    begin
        hit_cnt_d = hit_cnt_q;
        lock_d = lock_q;
        boost_d = boost_q;
        if (!lock_detect_en_i)
        begin
            hit_cnt_d = '0;
            lock_d = 1'b0;
        end
        else if (out_window)
        begin
            hit_cnt_d = '0;
            lock_d = 1'b0;
        end
        else if (in_window)
        begin
            if (hit_cnt_q + LOCK_CNT_W'(1) >= hit_target)
            begin
                lock_d = 1'b1;
                hit_cnt_d = hit_target;
            end
            else
            begin
                hit_cnt_d = hit_cnt_q + LOCK_CNT_W'(1);
            end
        end
        // Boost while the pending edge has run past four times the guard count
        boost_d = (state_q != pll_lock_pkg::ST_IDLE) && (slip_guard_i != '0)
            && ((win_len - win_cnt_q) > (WW'(slip_guard_i) << 2));
    end

    // Pump current decode, linear in code
    always_comb
    begin
        up_ua_d = CW'(pump_up_current_code_i)
            * CW'(pll_lock_pkg::PUMP_UA_PER_CODE);
        dn_ua_d = CW'(pump_down_current_code_i)
            * CW'(pll_lock_pkg::PUMP_UA_PER_CODE);
        off_ua = CW'(offset_code_i) * CW'(pll_lock_pkg::OFFSET_STEP_UA);
        offu_d = offset_up_en_i ? off_ua : '0;
        offd_d = offset_down_en_i ? off_ua : '0;
        int_mode_d = !frac_mod_en_i && mod_bypass_i;
        // Divider only even and within 2..62, odd values round down; below
        // 2 stays on the fundamental, so the oscillator never leaves its band
        odiv_d = (out_divide_i < pll_lock_pkg::ODIV_MIN) ? '0
            : {out_divide_i[pll_lock_pkg::ODIV_W-1:1], 1'b0};
        dbl_d = doubler_en_i && (odiv_d == '0);
    end

    // All state registers
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= pll_lock_pkg::ST_IDLE;
            win_cnt_q <= '0;
            hit_cnt_q <= '0;
            lock_q <= 1'b0;
            boost_q <= 1'b0;
            up_ua_q <= '0;
            dn_ua_q <= '0;
            offu_q <= '0;
            offd_q <= '0;
            int_mode_q <= 1'b0;
            odiv_q <= '0;
            dbl_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            win_cnt_q <= win_cnt_d;
            hit_cnt_q <= hit_cnt_d;
            lock_q <= lock_d;
            boost_q <= boost_d;
            up_ua_q <= up_ua_d;
            dn_ua_q <= dn_ua_d;
            offu_q <= offu_d;
            offd_q <= offd_d;
            int_mode_q <= int_mode_d;
            odiv_q <= odiv_d;
            dbl_q <= dbl_d;
        end
    end

    assign lock_indicator_o = lock_q;
    assign gain_boost_o = boost_q;
    assign pump_up_ua_o = up_ua_q;
    assign pump_down_ua_o = dn_ua_q;
    assign offset_up_ua_o = offu_q;
    assign offset_down_ua_o = offd_q;
    assign integer_mode_o = int_mode_q;
    assign out_divide_o = odiv_q;
    assign doubler_o = dbl_q;

    // Checks
    property p_miss_drops_lock;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        out_window |=> !lock_indicator_o;
    endproperty
    a_miss_drops_lock: assert property (p_miss_drops_lock)
        else $error("lock kept after a miss");
    property p_lock_needs_hit;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(lock_indicator_o) |-> $past(in_window);
    endproperty
    a_lock_needs_hit: assert property (p_lock_needs_hit)
        else $error("lock rose without an in-window edge");
    property p_first_edge_opens;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (state_q == pll_lock_pkg::ST_IDLE && ref_edge_i && !vco_edge_i
         && lock_detect_en_i) |=> (state_q == pll_lock_pkg::ST_WAIT_VCO
         && win_cnt_q == $past(win_len));
    endproperty
    a_first_edge_opens: assert property (p_first_edge_opens)
        else $error("window did not open on reference edge");
    property p_vco_first;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (state_q == pll_lock_pkg::ST_IDLE && vco_edge_i && !ref_edge_i
         && lock_detect_en_i) |=> state_q == pll_lock_pkg::ST_WAIT_REF;
    endproperty
    a_vco_first: assert property (p_vco_first)
        else $error("window did not open on oscillator edge");
    property p_pump_linear;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (pump_up_current_code_i == 7'h32) |=> pump_up_ua_o == 12'h3E8;
    endproperty
    a_pump_linear: assert property (p_pump_linear)
        else $error("code 50 does not give 1 mA");
    property p_offset_route;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !offset_down_en_i |=> offset_down_ua_o == '0;
    endproperty
    a_offset_route: assert property (p_offset_route)
        else $error("down offset applied while disabled");
    property p_offset_max;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (offset_code_i == 7'h7F && offset_up_en_i)
        |=> offset_up_ua_o == 12'h27B;
    endproperty
    a_offset_max: assert property (p_offset_max)
        else $error("offset full scale is not 635 uA");
    property p_divider_even;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        out_divide_o[0] == 1'b0 && !(doubler_o && out_divide_o != '0);
    endproperty
    a_divider_even: assert property (p_divider_even)
        else $error("odd divider or doubler with divider");
    property p_boost_only_pending;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        gain_boost_o |-> $past(state_q) != pll_lock_pkg::ST_IDLE;
    endproperty
    a_boost_only_pending: assert property (p_boost_only_pending)
        else $error("gain boost with no pending edge");

endmodule : pll_lock_window_pump_control

/* tb/phase_edge_model.sv */
`timescale 1ns/1ps
// Far side: divided reference and oscillator edges at the comparator
module phase_edge_model #(
    parameter int PERIOD = 40
) (
    // Clock
    input wire logic ref_clk_i,
    // Edges toward the comparator
    output logic ref_edge_o,
    output logic vco_edge_o
);
    logic first_q;
    logic second_q;
    logic vco_first_q;

    // Either input may lead; route the leading pulse accordingly
    assign ref_edge_o = vco_first_q ? second_q : first_q;
    assign vco_edge_o = vco_first_q ? first_q : second_q;

    // Quiet lines from time zero
    initial
    begin
        first_q = 1'b0;
        second_q = 1'b0;
        vco_first_q = 1'b0;
    end

    // One comparator period, entered at a falling edge
    task automatic pair(input logic vco_first, input int gap);
        vco_first_q = vco_first;
        first_q = 1'b1;
        second_q = (gap == 0);
        @(negedge ref_clk_i);
        first_q = 1'b0;
        second_q = 1'b0;
        if (gap > 0)
        begin
            repeat (gap - 1) @(negedge ref_clk_i);
            second_q = 1'b1;
            @(negedge ref_clk_i);
            second_q = 1'b0;
        end
        // Long idle so every window expires before the next period
        repeat (PERIOD) @(negedge ref_clk_i);
    endtask : pair
endmodule : phase_edge_model

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ref_edge_i;
    logic vco_edge_i;
    logic lock_detect_en_i = 1'b0;
    logic timer_window_sel_i = 1'b1;
    logic [2:0] timer_divide_i = 3'h0;
    logic [1:0] timer_speed_i = 2'h0;
    logic [2:0] lock_count_code_i = 3'h0;
    logic [6:0] pump_down_current_code_i = 7'h32;
    logic [6:0] pump_up_current_code_i = 7'h32;
    logic [6:0] offset_code_i = 7'h00;
    logic offset_up_en_i = 1'b0;
    logic offset_down_en_i = 1'b0;
    logic [1:0] slip_guard_i = 2'h0;
    logic frac_mod_en_i = 1'b0;
    logic mod_bypass_i = 1'b1;
    logic [5:0] out_divide_i = 6'h00;
    logic doubler_en_i = 1'b0;
    logic lock_indicator_o;
    logic gain_boost_o;
    logic [11:0] pump_up_ua_o;
    logic [11:0] pump_down_ua_o;
    logic [11:0] offset_up_ua_o;
    logic [11:0] offset_down_ua_o;
    logic integer_mode_o;
    logic [5:0] out_divide_o;
    logic doubler_o;
    int boost_cnt = 0;
    int boost_base;
    int n_fail = 0;
    int num_checks = 0;
    int wl;
    logic [2:0] cdiv[3] = '{3'h2, 3'h0, 3'h3};
    logic [1:0] cspd[3] = '{2'h1, 2'h3, 2'h0};
    logic [5:0] dv_in[4] = '{6'h02, 6'h3E, 6'h3F, 6'h01};
    logic [5:0] dv_exp[4] = '{6'h02, 6'h3E, 6'h3E, 6'h00};

    pll_lock_window_pump_control dut (.*);
    phase_edge_model edges (
        .ref_clk_i(ref_clk_i),
        .ref_edge_o(ref_edge_i),
        .vco_edge_o(vco_edge_i)
    );

    // Free-running 10 MHz clock
    initial
    begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Boost is brief, so count sightings; only this process writes it
    always @(posedge ref_clk_i)
        if (gain_boost_o === 1'b1)
            boost_cnt <= boost_cnt + 1;

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    // Registered decode needs one edge; two falling edges is safe
    task automatic settle();
        repeat (2) @(negedge ref_clk_i);
    endtask : settle

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Hang guard, well past the expected few thousand cycles
    initial
    begin
        #1_000_000;
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        repeat (20) @(negedge ref_clk_i);
        check(pump_up_ua_o, 12'h000);
        check({11'h000, lock_indicator_o}, 12'h000);
        resetn_i = 1'b1;
        settle();
        check(pump_up_ua_o, 12'h3E8);
        check(pump_down_ua_o, 12'h3E8);
        pump_up_current_code_i = 7'h7F;
        pump_down_current_code_i = 7'h01;
        settle();
        check(pump_up_ua_o, 12'h9EC);
        check(pump_down_ua_o, 12'h014);
        offset_code_i = 7'h7F;
        for (int k = 0; k < 4; k++)
        begin
            {offset_down_en_i, offset_up_en_i} = k[1:0];
            settle();
            check(offset_up_ua_o, k[0] ? 12'h27B : 12'h000);
            check(offset_down_ua_o, k[1] ? 12'h27B : 12'h000);
            {frac_mod_en_i, mod_bypass_i} = k[1:0];
            settle();
            check({11'h000, integer_mode_o}, {11'h000, k == 1});
        end
        doubler_en_i = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            out_divide_i = dv_in[k];
            settle();
            check({6'h00, out_divide_o}, {6'h00, dv_exp[k]});
            check({11'h000, doubler_o}, {11'h000, k == 3});
        end
        $display("test decode done");
        // Integer-mode settings with offset off while edges run
        {frac_mod_en_i, mod_bypass_i, offset_down_en_i} = 3'h2;
        offset_up_en_i = 1'b0;
        for (int c = 0; c < 3; c++)
        begin
            wl = (1 << cdiv[c]) * (cspd[c] + 1);
            timer_divide_i = cdiv[c];
            timer_speed_i = cspd[c];
            lock_detect_en_i = 1'b1;
            repeat (5) edges.pair(c == 1, wl - 1);
            check({11'h000, lock_indicator_o}, 12'h001);
            edges.pair(c == 1, wl + 2);
            check({11'h000, lock_indicator_o}, 12'h000);
            edges.pair(1'b0, 1);
            check({11'h000, lock_indicator_o}, 12'h000);
            lock_detect_en_i = 1'b0;
            settle();
        end
        $display("test window done");
        timer_divide_i = 3'h2;
        timer_speed_i = 2'h1;
        for (int k = 0; k < 3; k++)
        begin
            lock_count_code_i = k[2:0];
            lock_detect_en_i = 1'b1;
            repeat ((4 << k) - 1) edges.pair(1'b0, 2);
            check({11'h000, lock_indicator_o}, 12'h000);
            edges.pair(1'b0, 0);
            check({11'h000, lock_indicator_o}, 12'h001);
            lock_detect_en_i = 1'b0;
            settle();
            check({11'h000, lock_indicator_o}, 12'h000);
        end
        $display("test lock count done");
        timer_divide_i = 3'h4;
        timer_speed_i = 2'h0;
        // Gap 12 waits at most 11 cycles, so guard 3 (12) must stay quiet
        for (int s = 0; s < 4; s++)
        begin
            slip_guard_i = s[1:0];
            boost_base = boost_cnt;
            lock_detect_en_i = 1'b1;
            edges.pair(1'b0, 12);
            check(12'(boost_cnt != boost_base), 12'(s != 0 && s < 3));
            lock_detect_en_i = 1'b0;
            settle();
        end
        $display("test slip guard done");
        tally_and_finish();
    end
endmodule : tb
